// file: core/etc_pkg.sv
// Purpose: constants and types for the exposure trigger control block
// Assumes: one 50 MHz clock, apb register access
// Notes:   register offsets are byte addresses of aligned 32-bit words
package etc_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] ETC_ADDR_MODE   = 8'h00;
  localparam logic [7:0] ETC_ADDR_POL    = 8'h04;
  localparam logic [7:0] ETC_ADDR_DIV    = 8'h08;
  localparam logic [7:0] ETC_ADDR_MUL    = 8'h0c;
  localparam logic [7:0] ETC_ADDR_DUR_US = 8'h10;
  localparam logic [7:0] ETC_ADDR_DUR_TK = 8'h14;
  localparam logic [7:0] ETC_ADDR_AUTO   = 8'h18;
  localparam logic [7:0] ETC_ADDR_STATUS = 8'h1c;
  localparam logic [7:0] ETC_ADDR_TARGET = 8'h20;

  // ****************************************************************
  // reset values and timing
  // ****************************************************************
  localparam int          ETC_CLK_MHZ      = 50;
  localparam int          ETC_TICK_NS      = 1000;
  localparam int          ETC_TICK_CYCLES  = (ETC_TICK_NS * ETC_CLK_MHZ) / 1000;
  localparam logic [15:0] ETC_RST_FACTOR   = 16'h0001;
  localparam logic [23:0] ETC_RST_DUR      = 24'h0003e8;
  localparam logic [15:0] ETC_RST_TARGET   = 16'h0800;
  localparam logic [23:0] ETC_AUTO_STEP    = 24'h000010;
  localparam logic [15:0] ETC_AUTO_TOL     = 16'h0040;
  localparam logic [23:0] ETC_DUR_MAX      = 24'hffffff;

  // ****************************************************************
  // encodings
  // ****************************************************************
  typedef enum logic [1:0] {
    ETC_MODE_OFF   = 2'h0,
    ETC_MODE_TIMED = 2'h1,
    ETC_MODE_WIDTH = 2'h2,
    ETC_MODE_DEDIC = 2'h3
  } etc_mode_t;

  typedef enum logic [2:0] {
    ETC_ACT_RISE   = 3'h0,
    ETC_ACT_FALL   = 3'h1,
    ETC_ACT_EITHER = 3'h2,
    ETC_ACT_HIGH   = 3'h3,
    ETC_ACT_LOW    = 3'h4
  } etc_act_t;

  typedef enum logic [1:0] {
    ETC_AUTO_OFF  = 2'h0,
    ETC_AUTO_ONCE = 2'h1,
    ETC_AUTO_CONT = 2'h2
  } etc_auto_t;

  typedef enum logic [2:0] {
    ETC_SH_IDLE = 3'b001,
    ETC_SH_OPEN = 3'b010,
    ETC_SH_HOLD = 3'b100
  } etc_sh_t;

endpackage

// file: core/etc_top.sv
// Purpose: trigger rate scaling and shutter control with apb registers
// Assumes: trigger, level and brightness inputs synchronous to i_clk_sys
// Notes:   one duration tick equals one microsecond, so both views agree
`timescale 1ns/1ps
module etc_top
#(
  parameter int FACTOR_W = 16,
  parameter int DUR_W    = 24
)
(
  // clock and reset
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_sys_rst,
  // apb slave
  input  wire logic                     i_psel,
  input  wire logic                     i_penable,
  input  wire logic                     i_pwrite,
  input  wire logic [7:0]               i_paddr,
  input  wire logic [31:0]              i_pwdata,
  output logic      [31:0]              o_prdata,
  output logic                          o_pready,
  output logic                          o_pslverr,
  // trigger sources
  input  wire logic                     i_frame_trigger,
  input  wire logic                     i_frame_begin_event,
  input  wire logic                     i_shutter_open_trigger,
  input  wire logic                     i_shutter_close_trigger,
  input  wire logic                     i_shutter_level_trigger,
  // image brightness sample for auto shutter
  input  wire logic                     i_bright_valid,
  input  wire logic [15:0]              i_bright_level,
  // outputs
  output logic                          o_scaled_trigger,
  output logic                          o_shutter_open,
  output etc_pkg::etc_mode_t            o_shutter_operation_select
);
  import etc_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    etc_mode_t             mode;
    etc_act_t              pol;
    logic [FACTOR_W-1:0]   div;
    logic [FACTOR_W-1:0]   mul;
    logic [DUR_W-1:0]      dur;
    etc_auto_t             auto_sel;
    logic [15:0]           target;
    logic                  trig_d;
    logic                  open_d;
    logic                  close_d;
    logic                  begin_d;
    logic [FACTOR_W-1:0]   div_cnt;
    logic [FACTOR_W-1:0]   mul_left;
    logic                  mul_gap;
    logic                  scaled;
    etc_sh_t               sh;
    logic [DUR_W-1:0]      dur_cnt;
    logic [7:0]            tick_cnt;
    logic                  shutter;
    logic                  converged;
    logic [31:0]           prdata;
  } etc_state_t;

  etc_state_t st_r;
  etc_state_t st_nxt;

  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic        trig_valid;
  logic        trig_edge_rise;
  logic        trig_edge_fall;
  logic        width_active;
  logic        open_evt;
  logic        close_evt;
  logic        dedic_active;
  logic        tick;
  logic [15:0] err;
  logic        begin_evt;

  // burst arithmetic, one bit wider to catch saturation
  logic [FACTOR_W-1:0] burst_left;
  logic [FACTOR_W:0]   burst_sum;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  always_comb
  begin
    case (i_paddr)
      ETC_ADDR_MODE, ETC_ADDR_POL, ETC_ADDR_DIV, ETC_ADDR_MUL,
      ETC_ADDR_DUR_US, ETC_ADDR_DUR_TK, ETC_ADDR_AUTO,
      ETC_ADDR_STATUS, ETC_ADDR_TARGET: addr_ok = 1'b1;
      default:                          addr_ok = 1'b0;
    endcase
  end

  // zero wait states; unmapped addresses answer with pslverr
  assign wr_en     = i_psel && i_penable && i_pwrite && addr_ok;
  assign rd_en     = i_psel && !i_penable && !i_pwrite;
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && !addr_ok;
  assign o_prdata  = st_r.prdata;

  // ****************************************************************
  // trigger qualification
  // ****************************************************************
  // edge history resets low like the idle pins, so no false edge
  assign trig_edge_rise = i_frame_trigger && !st_r.trig_d;
  assign trig_edge_fall = !i_frame_trigger && st_r.trig_d;

  always_comb
  begin
    case (st_r.pol)
      ETC_ACT_RISE:   trig_valid = trig_edge_rise;
      ETC_ACT_FALL:   trig_valid = trig_edge_fall;
      ETC_ACT_EITHER: trig_valid = trig_edge_rise || trig_edge_fall;
      ETC_ACT_HIGH:   trig_valid = i_frame_trigger;
      ETC_ACT_LOW:    trig_valid = !i_frame_trigger;
      default:        trig_valid = 1'b0;
    endcase
  end

  // width follows the level matching the polarity
  always_comb
  begin
    case (st_r.pol)
      ETC_ACT_RISE, ETC_ACT_HIGH, ETC_ACT_EITHER: width_active = i_frame_trigger;
      ETC_ACT_FALL, ETC_ACT_LOW:                  width_active = !i_frame_trigger;
      default:                                    width_active = 1'b0;
    endcase
  end

  // only honoured in dedicated mode; other modes ignore them
  assign open_evt     = (st_r.mode == ETC_MODE_DEDIC) &&
                        i_shutter_open_trigger && !st_r.open_d;
  assign close_evt    = (st_r.mode == ETC_MODE_DEDIC) &&
                        i_shutter_close_trigger && !st_r.close_d;
  assign dedic_active = (st_r.mode == ETC_MODE_DEDIC) && i_shutter_level_trigger;
  assign begin_evt    = i_frame_begin_event && !st_r.begin_d;
  assign tick         = (st_r.tick_cnt == 8'(ETC_TICK_CYCLES - 1));
  assign err          = (i_bright_level > st_r.target) ? i_bright_level - st_r.target
                                                       : st_r.target - i_bright_level;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    st_nxt         = st_r;
    st_nxt.trig_d  = i_frame_trigger;
    st_nxt.open_d  = i_shutter_open_trigger;
    st_nxt.close_d = i_shutter_close_trigger;
    st_nxt.begin_d = i_frame_begin_event;
    st_nxt.scaled  = 1'b0;

    // register writes
    if (wr_en)
    begin
      case (i_paddr)
        ETC_ADDR_MODE: st_nxt.mode = etc_mode_t'(i_pwdata[1:0]);
        ETC_ADDR_POL:  st_nxt.pol  = (i_pwdata[2:0] > 3'h4) ? st_r.pol
                                                            : etc_act_t'(i_pwdata[2:0]);
        ETC_ADDR_DIV:  st_nxt.div  = (i_pwdata[FACTOR_W-1:0] == '0) ? st_r.div
                                                                   : i_pwdata[FACTOR_W-1:0];
        ETC_ADDR_MUL:  st_nxt.mul  = (i_pwdata[FACTOR_W-1:0] == '0) ? st_r.mul
                                                                   : i_pwdata[FACTOR_W-1:0];
        // both views land in one store, so readback always agrees
        ETC_ADDR_DUR_US: st_nxt.dur = i_pwdata[DUR_W-1:0];
        ETC_ADDR_DUR_TK: st_nxt.dur = i_pwdata[DUR_W-1:0];
        ETC_ADDR_AUTO: st_nxt.auto_sel = (i_pwdata[1:0] == 2'h3) ? st_r.auto_sel
                                                                 : etc_auto_t'(i_pwdata[1:0]);
        ETC_ADDR_TARGET: st_nxt.target = i_pwdata[15:0];
        default: st_nxt.target = st_r.target;
      endcase
      if (i_paddr == ETC_ADDR_AUTO)
      begin
        st_nxt.converged = 1'b0;
      end
    end

    // read data captured in setup phase
    if (rd_en)
    begin
      case (i_paddr)
        ETC_ADDR_MODE:   st_nxt.prdata = {30'h0, st_r.mode};
        ETC_ADDR_POL:    st_nxt.prdata = {29'h0, st_r.pol};
        ETC_ADDR_DIV:    st_nxt.prdata = 32'(st_r.div);
        ETC_ADDR_MUL:    st_nxt.prdata = 32'(st_r.mul);
        ETC_ADDR_DUR_US: st_nxt.prdata = 32'(st_r.dur);
        ETC_ADDR_DUR_TK: st_nxt.prdata = 32'(st_r.dur);
        ETC_ADDR_AUTO:   st_nxt.prdata = {30'h0, st_r.auto_sel};
        ETC_ADDR_STATUS: st_nxt.prdata = {28'h0, st_r.converged, st_r.shutter,
                                          st_r.sh == ETC_SH_OPEN, st_r.scaled};
        ETC_ADDR_TARGET: st_nxt.prdata = {16'h0, st_r.target};
        default:         st_nxt.prdata = 32'h0;
      endcase
    end

    // one pulse per two cycles so each burst pulse is distinct
    burst_left = st_r.mul_left;
    if (st_r.mul_left != '0 && !st_r.mul_gap)
    begin
      st_nxt.scaled  = 1'b1;
      burst_left     = st_r.mul_left - 1'b1;
      st_nxt.mul_gap = 1'b1;
    end
    else
    begin
      st_nxt.mul_gap = 1'b0;
    end

    // rate scaler: every div-th valid trigger adds mul pulses; a trigger
    // taken mid-burst extends it; the count saturates at all ones, so pulses beyond that are lost
    // level polarities count every cycle, so a long level saturates when twice mul exceeds div
    burst_sum = {1'b0, burst_left} + {1'b0, st_r.mul};
    if (trig_valid)
    begin
      if (st_r.div_cnt >= st_r.div - 1'b1)
      begin
        st_nxt.div_cnt = '0;
        burst_left     = burst_sum[FACTOR_W] ? '1 : burst_sum[FACTOR_W-1:0];
      end
      else
      begin
        st_nxt.div_cnt = st_r.div_cnt + 1'b1;
      end
    end
    st_nxt.mul_left = burst_left;

    // microsecond tick divider, only in timed exposure
    // idles at zero so every exposure starts on a whole tick
    st_nxt.tick_cnt = (st_r.sh == ETC_SH_OPEN && !tick) ? st_r.tick_cnt + 8'h1 : 8'h0;

    // shutter sequencing
    case (st_r.mode)
      ETC_MODE_OFF:
      begin
        st_nxt.sh      = ETC_SH_IDLE;
        st_nxt.shutter = 1'b1;
      end
      ETC_MODE_TIMED:
      begin
        case (st_r.sh)
          ETC_SH_IDLE:
          begin
            st_nxt.shutter = 1'b0;
            if (begin_evt && st_r.dur != '0)
            begin
              st_nxt.sh      = ETC_SH_OPEN;
              st_nxt.dur_cnt = st_r.dur;
              st_nxt.shutter = 1'b1;
            end
          end
          ETC_SH_OPEN:
          begin
            if (tick)
            begin
              st_nxt.dur_cnt = st_r.dur_cnt - 1'b1;
              if (st_r.dur_cnt == 1)
              begin
                st_nxt.sh      = ETC_SH_IDLE;
                st_nxt.shutter = 1'b0;
              end
            end
          end
          default:
          begin
            st_nxt.sh      = ETC_SH_IDLE;
            st_nxt.shutter = 1'b0;
          end
        endcase
      end
      ETC_MODE_WIDTH:
      begin
        st_nxt.sh      = ETC_SH_IDLE;
        st_nxt.shutter = width_active;
      end
      ETC_MODE_DEDIC:
      begin
        // open/close pair holds; level trigger ors in
        if (open_evt)
        begin
          st_nxt.sh = ETC_SH_HOLD;
        end
        else if (close_evt)
        begin
          st_nxt.sh = ETC_SH_IDLE;
        end
        else if (st_r.sh != ETC_SH_HOLD)
        begin
          st_nxt.sh = ETC_SH_IDLE;
        end
        st_nxt.shutter = (open_evt || (st_r.sh == ETC_SH_HOLD && !close_evt)) ||
                         dedic_active;
      end
      default:
      begin
        st_nxt.sh      = ETC_SH_IDLE;
        st_nxt.shutter = 1'b0;
      end
    endcase

    // a stale convergence flag means nothing outside timed mode
    if (st_r.mode != ETC_MODE_TIMED)
    begin
      st_nxt.converged = 1'b0;
    end

    // auto shutter: step toward target brightness, timed mode only
    // a register write in the same cycle wins over the step
    if (st_r.mode == ETC_MODE_TIMED && st_r.auto_sel != ETC_AUTO_OFF &&
        i_bright_valid && !wr_en)
    begin
      if (err <= ETC_AUTO_TOL)
      begin
        st_nxt.converged = 1'b1;
        if (st_r.auto_sel == ETC_AUTO_ONCE)
        begin
          st_nxt.auto_sel = ETC_AUTO_OFF;
        end
      end
      else
      begin
        st_nxt.converged = 1'b0;
        if (i_bright_level < st_r.target)
        begin
          st_nxt.dur = (st_r.dur > ETC_DUR_MAX - ETC_AUTO_STEP) ? ETC_DUR_MAX
                                                                : st_r.dur + ETC_AUTO_STEP;
        end
        else
        begin
          st_nxt.dur = (st_r.dur > ETC_AUTO_STEP) ? st_r.dur - ETC_AUTO_STEP : 24'h1;
        end
      end
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      st_r          <= '0;
      st_r.mode     <= ETC_MODE_OFF;
      st_r.pol      <= ETC_ACT_RISE;
      st_r.div      <= ETC_RST_FACTOR;
      st_r.mul      <= ETC_RST_FACTOR;
      st_r.dur      <= ETC_RST_DUR;
      st_r.auto_sel <= ETC_AUTO_OFF;
      st_r.target   <= ETC_RST_TARGET;
      st_r.sh       <= ETC_SH_IDLE;
      st_r.shutter  <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign o_scaled_trigger           = st_r.scaled;
  assign o_shutter_open             = st_r.shutter;
  assign o_shutter_operation_select = st_r.mode;

endmodule

// file: verification/etc_assertions.sv
// Purpose: port checks of the exposure trigger control block
// Assumes: one clock, async active-high reset
// Notes:   polarity is rebuilt from apb writes, it is no port
`timescale 1ns/1ps
module etc_assertions
#(
  parameter int FACTOR_W = 16,
  parameter int DUR_W    = 24
)
(
  // clock, reset, apb
  input wire logic               i_clk_sys,
  input wire logic               i_sys_rst,
  input wire logic               i_psel,
  input wire logic               i_penable,
  input wire logic               i_pwrite,
  input wire logic [7:0]         i_paddr,
  input wire logic [31:0]        i_pwdata,
  input wire logic [31:0]        o_prdata,
  input wire logic               o_pready,
  input wire logic               o_pslverr,
  // triggers and shutter
  input wire logic               i_frame_trigger,
  input wire logic               i_shutter_open_trigger,
  input wire logic               o_scaled_trigger,
  input wire logic               o_shutter_open,
  input wire etc_pkg::etc_mode_t o_shutter_operation_select
);
  import etc_pkg::*;
  logic       acc;
  logic       pol_ok_r;
  logic [2:0] pol_r;
  etc_mode_t  sel;
  assign acc = i_psel && i_penable;
  assign sel = o_shutter_operation_select;
  // polarity is invisible, so unknown until software writes it
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      pol_ok_r <= 1'b0;
      pol_r    <= 3'h0;
    end
    else if (acc && i_pwrite && i_paddr == ETC_ADDR_POL && i_pwdata[2:0] <= 3'h4)
    begin
      pol_ok_r <= 1'b1;
      pol_r    <= i_pwdata[2:0];
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  chk_bad_addr_err: assert property (acc && i_paddr > ETC_ADDR_TARGET |-> o_pslverr)
    else $error("unmapped access without error");
  chk_bad_read_zero: assert property (acc && !i_pwrite && i_paddr > ETC_ADDR_TARGET
    |-> o_prdata == 32'h0) else $error("unmapped read not zero");
  chk_mode_write: assert property (acc && i_pwrite && i_paddr == ETC_ADDR_MODE
    && i_pwdata[31:2] == 30'h0 |=> {30'h0, sel} == $past(i_pwdata))
    else $error("mode write not taken");
  chk_off_open: assert property (sel == ETC_MODE_OFF && $stable(sel) |-> o_shutter_open)
    else $error("shutter closed in off mode");
  chk_width_high: assert property (sel == ETC_MODE_WIDTH && $stable(sel) && pol_ok_r
    && $stable(pol_r) && pol_r inside {3'h0, 3'h2, 3'h3}
    |-> o_shutter_open == $past(i_frame_trigger)) else $error("width high mismatch");
  chk_width_low: assert property (sel == ETC_MODE_WIDTH && $stable(sel) && pol_ok_r
    && $stable(pol_r) && pol_r inside {3'h1, 3'h4}
    |-> o_shutter_open == !$past(i_frame_trigger)) else $error("width low mismatch");
  chk_pulse_single: assert property (o_scaled_trigger |=> !o_scaled_trigger)
    else $error("scaled pulse too long");
  chk_open_edge: assert property (sel == ETC_MODE_DEDIC && $stable(sel)
    && $rose(i_shutter_open_trigger) |-> ##[1:2] o_shutter_open)
    else $error("shutter did not open");
  cov_scaled: cover property (o_scaled_trigger);
  cov_timed: cover property (sel == ETC_MODE_TIMED && o_shutter_open);
  cov_err: cover property (o_pslverr);
endmodule
bind etc_top etc_assertions #(.FACTOR_W(FACTOR_W), .DUR_W(DUR_W)) etc_assertions_i (.*);

// file: verification/etc_partner.sv
// Purpose: trigger sources and brightness sampler beside the block
// Assumes: lines change only just after a rising edge
// Notes:   line index 0 frame, 1 begin, 2 open, 3 close, 4 level
`timescale 1ns/1ps
module etc_partner
(
  // clock
  input  wire logic   i_clk_sys,
  // trigger lines and brightness
  output logic [4:0]  o_trig,
  output logic        o_bright_valid,
  output logic [15:0] o_bright_level
);
  initial
  begin
    o_trig = 5'h0;
    o_bright_valid = 1'b0;
    o_bright_level = 16'h0;
  end
  task automatic pulse(input int ln, input int w);
    @(posedge i_clk_sys);
    o_trig[ln] <= 1'b1;
    repeat (w) @(posedge i_clk_sys);
    o_trig[ln] <= 1'b0;
  endtask
  task automatic bright(input logic [15:0] lv);
    @(posedge i_clk_sys);
    o_bright_valid <= 1'b1;
    o_bright_level <= lv;
    @(posedge i_clk_sys);
    o_bright_valid <= 1'b0;
    // stale sample is not held once valid drops
    o_bright_level <= ~lv;
  endtask
endmodule

// file: verification/tb_exposure_trigger_control.sv
// Purpose: random and corner tests of the exposure trigger control
// Assumes: 50 MHz clock, one duration tick is one microsecond
// Notes:   shutter and pulse cycles are counted over windows
`timescale 1ns/1ps
module tb_exposure_trigger_control;
  import etc_pkg::*;
  logic        clk, rst, psel, pen, pwr, pready, pslverr, scaled, shut, bv, er, cnt_en;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic [4:0]  trig;
  logic [15:0] bl;
  etc_mode_t   msel;
  int          miscompares, total_checks, sh_cnt, sc_cnt, win, n;
  logic [7:0]  ra[7] = '{ETC_ADDR_MODE, ETC_ADDR_DIV, ETC_ADDR_MUL, ETC_ADDR_DUR_US,
                         ETC_ADDR_DUR_TK, ETC_ADDR_AUTO, ETC_ADDR_TARGET};
  logic [31:0] rv[7] = '{32'h0, 32'h1, 32'h1, 32'h3e8, 32'h3e8, 32'h0, 32'h800};
  int          ex_act[4] = '{1, 1, 2, 1};
  int          w_act[4] = '{3, 3, 3, 1};
  etc_top etc_top_i (.i_clk_sys(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_frame_trigger(trig[0]),
    .i_frame_begin_event(trig[1]), .i_shutter_open_trigger(trig[2]),
    .i_shutter_close_trigger(trig[3]), .i_shutter_level_trigger(trig[4]),
    .i_bright_valid(bv), .i_bright_level(bl), .o_scaled_trigger(scaled),
    .o_shutter_open(shut), .o_shutter_operation_select(msel));
  etc_partner etc_partner_i (.i_clk_sys(clk), .o_trig(trig), .o_bright_valid(bv),
    .o_bright_level(bl));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (cnt_en)
    begin
      win++;
      sh_cnt += (shut === 1'b1);
      sc_cnt += (scaled === 1'b1);
    end
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_cnt(input int got, input int exp);
    total_checks++;
    if (got != exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // expected counts from the programmed settings
  function automatic int exp_pulses(input int pulses, input int dv, input int ml);
    return pulses / dv * ml;
  endfunction
  function automatic int exp_timed(input int dur_us);
    return dur_us * ETC_TICK_CYCLES;
  endfunction
  // zero-wait slave, but the wait stays open-ended up to a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++k < 50);
    if (k >= 50)
      miscompares++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    cmp_reg(rd, exp);
  endtask
  // one idle edge first so a just-written setting is in force
  task automatic win_on;
    @(posedge clk);
    sh_cnt = 0;
    sc_cnt = 0;
    win = 0;
    cnt_en <= 1'b1;
  endtask
  task automatic win_off(input int k);
    repeat (k) @(posedge clk);
    cnt_en <= 1'b0;
    @(posedge clk);
  endtask
  task automatic auto_step(input logic [1:0] md, input logic [1:0] au, input logic [15:0] lv,
                           input logic [31:0] dlt, input logic [1:0] aex);
    logic [31:0] d0;
    apb(1'b1, ETC_ADDR_MODE, {30'h0, md});
    apb(1'b1, ETC_ADDR_AUTO, {30'h0, au});
    apb(1'b0, ETC_ADDR_DUR_US, 32'h0);
    d0 = rd;
    etc_partner_i.bright(lv);
    repeat (4) @(posedge clk);
    rdchk(ETC_ADDR_DUR_US, d0 + dlt);
    rdchk(ETC_ADDR_AUTO, {30'h0, aex});
  endtask
  initial
  begin
    #400000;
    miscompares++;
    print_verdict();
  end
  initial
  begin
    {rst, psel, pen, pwr, paddr, pwdata, cnt_en} = {1'b1, 44'h0};
    miscompares = 0;
    total_checks = 0;
    v = $urandom(65);
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    foreach (ra[i]) rdchk(ra[i], rv[i]);
    apb(1'b1, 8'h40, $urandom);
    cmp_reg({31'h0, er}, 32'h1);
    rdchk(8'h40, 32'h0);
    v = 32'h1 + ($urandom % 32'hfffffe);
    apb(1'b1, ETC_ADDR_DUR_US, v);
    rdchk(ETC_ADDR_DUR_TK, v);
    apb(1'b1, ETC_ADDR_DUR_TK, v + 32'h1);
    rdchk(ETC_ADDR_DUR_US, v + 32'h1);
    apb(1'b1, ETC_ADDR_DIV, 32'h0);
    rdchk(ETC_ADDR_DIV, 32'h1);
    $display("test registers done");
    apb(1'b1, ETC_ADDR_POL, 32'h0);
    for (int d = 1; d <= 3; d++)
      for (int m = 1; m <= 3; m++)
      begin
        apb(1'b1, ETC_ADDR_DIV, d);
        apb(1'b1, ETC_ADDR_MUL, m);
        n = d * (1 + $urandom % 3);
        win_on();
        repeat (n)
        begin
          etc_partner_i.pulse(0, 2);
          repeat (2 * m + 4) @(posedge clk);
        end
        win_off(4);
        cmp_cnt(sc_cnt, exp_pulses(n, d, m));
      end
    apb(1'b1, ETC_ADDR_DIV, 32'h1);
    apb(1'b1, ETC_ADDR_MUL, 32'h1);
    for (int p = 0; p < 4; p++)
    begin
      apb(1'b1, ETC_ADDR_POL, p);
      win_on();
      etc_partner_i.pulse(0, w_act[p]);
      win_off(8);
      cmp_cnt(sc_cnt, ex_act[p]);
    end
    $display("test scaler done");
    apb(1'b1, ETC_ADDR_MODE, ETC_MODE_OFF);
    win_on();
    win_off(10);
    cmp_cnt(sh_cnt, win);
    apb(1'b1, ETC_ADDR_MODE, ETC_MODE_WIDTH);
    for (int p = 0; p < 5; p += 4)
    begin
      apb(1'b1, ETC_ADDR_POL, p);
      n = 2 + $urandom % 8;
      win_on();
      etc_partner_i.pulse(0, n);
      win_off(4);
      cmp_cnt(sh_cnt, (p == 0) ? n : win - n);
    end
    $display("test width done");
    apb(1'b1, ETC_ADDR_DUR_US, 32'h2);
    apb(1'b1, ETC_ADDR_MODE, ETC_MODE_TIMED);
    win_on();
    etc_partner_i.pulse(1, 1);
    win_off(110);
    cmp_cnt(sh_cnt, exp_timed(2));
    win_on();
    etc_partner_i.pulse(4, 5);
    etc_partner_i.pulse(2, 1);
    win_off(8);
    cmp_cnt(sh_cnt, 0);
    $display("test timed done");
    apb(1'b1, ETC_ADDR_MODE, ETC_MODE_DEDIC);
    n = 3 + $urandom % 10;
    win_on();
    cmp_reg({30'h0, msel}, {30'h0, ETC_MODE_DEDIC});
    etc_partner_i.pulse(2, 1);
    repeat (n) @(posedge clk);
    etc_partner_i.pulse(3, 1);
    win_off(6);
    cmp_cnt(sh_cnt, n + 2);
    win_on();
    etc_partner_i.pulse(4, n);
    etc_partner_i.pulse(0, 4);
    win_off(6);
    cmp_cnt(sh_cnt, n);
    $display("test dedicated done");
    auto_step(ETC_MODE_WIDTH, ETC_AUTO_CONT, 16'h100, 32'h0, ETC_AUTO_CONT);
    auto_step(ETC_MODE_TIMED, ETC_AUTO_OFF, 16'h100, 32'h0, ETC_AUTO_OFF);
    auto_step(ETC_MODE_TIMED, ETC_AUTO_CONT, 16'h100, 32'h10, ETC_AUTO_CONT);
    auto_step(ETC_MODE_TIMED, ETC_AUTO_ONCE, 16'h100, 32'h10, ETC_AUTO_ONCE);
    auto_step(ETC_MODE_TIMED, ETC_AUTO_ONCE, 16'h800, 32'h0, ETC_AUTO_OFF);
    $display("test auto done");
    print_verdict();
  end
endmodule
